// ### verilog/fpepc_top.sv
// flash program, erase and protect controller with apb registers
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
// Function
// (R1) erase sets a whole 1 kB block to ones
// (R2) protection kept per 2 kB region
// (R3) read-only region refuses erase and program
// (R4) execute-only allows fetches, blocks data reads
// (R5) protected erase refused and reported failed
// (R6) program stores AND of new and old
// (R7) requester programs whole aligned words only
// (R8) pulse timing counted from clocks per microsecond
// (R9) software loads clocks per microsecond first
// (R10) disallowed access sets violation flag
// (R11) finished erase or program sets done flag
// (R12) per source enable gates interrupt line
// (R13) raw and masked status both readable
// (R14) writing one clears selected flags
// (R15) software clears flag early in handler
// (R16) protection temporary until separate commit
// (R17) protection may only be tightened
// (R18) uncommitted protection lost at reset
// (R19) refused access changes nothing, flags violation
module fpepc_top (
  input  wire logic                      clk,        // system clock
  input  wire logic                      reset,      // sync, active high
  input  wire logic                      psel,       // apb select
  input  wire logic                      penable,    // apb enable
  input  wire logic                      pwrite,     // apb direction
  input  wire logic [11:0]               paddr,      // apb byte address
  input  wire logic [31:0]               pwdata,     // apb write data
  output logic      [31:0]               prdata,     // apb read data
  output logic                           pready,     // apb ready
  output logic                           pslverr,    // apb error
  input  wire fpepc_pkg::fpepc_fetch_req_t fetch_req,  // core/debug read
  output fpepc_pkg::fpepc_fetch_rsp_t    fetch_rsp,  // read answer
  output logic                           busy,       // operation running
  output logic                           irq         // level interrupt
);
  logic [31:0] mem_q [fpepc_pkg::WORDS];
  logic [1:0]  prot_q [fpepc_pkg::REGIONS];
  logic [1:0]  perm_q [fpepc_pkg::REGIONS];
  logic [31:0] data_q;
  logic [15:0] addr_q;
  logic [7:0]  usec_q;
  logic [1:0]  ris_q;
  logic [1:0]  im_q;
  logic        fail_q;
  logic [31:0] rdata_q;
  fpepc_pkg::fpepc_state_t state_q;
  logic [7:0]  tick_q;
  logic [7:0]  us_q;
  logic [11:0] idx_q;
  logic [7:0]  wcnt_q;

  ////////////////////////////////////////////////////////////////////////////
  logic        wr;
  logic        rd;
  logic [2:0]  reg_sel;
  logic [1:0]  op_prot;
  logic [1:0]  rd_prot;
  logic [2:0]  apb_rg;
  logic        us_tick;
  logic [7:0]  us_goal;
  logic        op_end;
  logic        viol_ev;
  logic        done_ev;
  logic        start_ok;
  logic        start_bad;
  logic        rd_bad;
  logic        fetch_bad;

  // writes commit at the edge that completes the access
  assign wr      = psel && penable && pwrite && pready;
  assign rd      = psel && penable && !pwrite && !pready;
  assign reg_sel = addr_q[fpepc_pkg::REG_SHIFT+2 +: 3];
  assign op_prot = prot_q[reg_sel];
  assign apb_rg  = pwdata[2:0];
  assign rd_prot = prot_q[fetch_req.addr[fpepc_pkg::REG_SHIFT+2 +: 3]];
  assign us_tick = (tick_q + 8'h01 >= usec_q);                // see (R8)
  assign us_goal = (state_q == fpepc_pkg::ST_ERASE)
                   ? 8'(fpepc_pkg::ERASE_US) : 8'(fpepc_pkg::PROG_US);
  assign op_end  = (state_q != fpepc_pkg::ST_IDLE) && us_tick
                   && (us_q + 8'h01 >= us_goal)
                   && (state_q == fpepc_pkg::ST_PROG || wcnt_q == 8'hFF);
  assign start_ok  = wr && paddr == fpepc_pkg::OFF_CMD && busy == 1'b0
                     && (pwdata[2:0] == fpepc_pkg::CMD_PROG
                         || pwdata[2:0] == fpepc_pkg::CMD_ERASE)
                     && op_prot == 2'(fpepc_pkg::PROT_RW);    // see (R3)
  assign start_bad = wr && paddr == fpepc_pkg::OFF_CMD && busy == 1'b0
                     && (pwdata[2:0] == fpepc_pkg::CMD_PROG
                         || pwdata[2:0] == fpepc_pkg::CMD_ERASE)
                     && op_prot != 2'(fpepc_pkg::PROT_RW);    // see (R5)
  assign rd_bad    = wr && paddr == fpepc_pkg::OFF_CMD
                     && pwdata[2:0] == fpepc_pkg::CMD_READ
                     && op_prot == 2'(fpepc_pkg::PROT_XO);    // see (R4)
  assign fetch_bad = fetch_req.valid && !fetch_req.fetch
                     && rd_prot == 2'(fpepc_pkg::PROT_XO);    // see (R4)
  assign viol_ev = start_bad || rd_bad || fetch_bad;          // see (R10)
  assign done_ev = op_end;                                    // see (R11)

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state, answer in the second access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (rd) begin
        unique case (paddr)
          fpepc_pkg::OFF_DATA:  prdata <= data_q;
          fpepc_pkg::OFF_ADDR:  prdata <= {16'h0000, addr_q};
          fpepc_pkg::OFF_STAT:  prdata <= {30'h0, fail_q, busy};
          fpepc_pkg::OFF_USEC:  prdata <= {24'h000000, usec_q};
          fpepc_pkg::OFF_RIS:   prdata <= {30'h0, ris_q};     // see (R13)
          fpepc_pkg::OFF_IM:    prdata <= {30'h0, im_q};
          fpepc_pkg::OFF_MIS:   prdata <= {30'h0, ris_q & im_q}; // see (R13)
          fpepc_pkg::OFF_PROT:  prdata <= {30'h0, prot_q[addr_q[
                                  fpepc_pkg::REG_SHIFT+2 +: 3]]};
          fpepc_pkg::OFF_RDATA: prdata <= rdata_q;
          default: begin
            prdata  <= 32'h00000000;
            pslverr <= (paddr > fpepc_pkg::OFF_RDATA);
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program data word
  always_ff @(posedge clk) begin
    if (reset) begin
      data_q <= 32'h00000000;
    end else if (wr && paddr == fpepc_pkg::OFF_DATA) begin
      data_q <= pwdata;
    end
  end

  // target address, frozen while an operation runs
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_q <= 16'h0000;
    end else if (wr && paddr == fpepc_pkg::OFF_ADDR && !busy) begin
      addr_q <= {pwdata[15:2], 2'b00};                        // see (R7)
    end
  end

  // clocks per microsecond for pulse timing
  always_ff @(posedge clk) begin
    if (reset) begin
      usec_q <= fpepc_pkg::USEC_RESET;
    end else if (wr && paddr == fpepc_pkg::OFF_USEC) begin
      usec_q <= pwdata[7:0];                                  // see (R9)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection: live copy reloads from committed copy at reset
  for (genvar g = 0; g < fpepc_pkg::REGIONS; g++) begin : g_prot // see (R2)
    always_ff @(posedge clk) begin
      if (reset) begin
        case (perm_q[g])
          2'(fpepc_pkg::PROT_RO), 2'(fpepc_pkg::PROT_XO): begin
            prot_q[g] <= perm_q[g];                           // see (R18)
          end
          default: prot_q[g] <= 2'(fpepc_pkg::PROT_RW);
        endcase
      end else if (wr && paddr == fpepc_pkg::OFF_PROT
                   && apb_rg == 3'(g)) begin
        if (prot_q[g] == 2'(fpepc_pkg::PROT_RW)
            && pwdata[9:8] != 2'b11) begin
          prot_q[g] <= pwdata[9:8];                           // see (R17)
        end else if (prot_q[g] == 2'(fpepc_pkg::PROT_RO)
                     && pwdata[9:8] == 2'(fpepc_pkg::PROT_XO)) begin
          prot_q[g] <= pwdata[9:8];                           // see (R17)
        end
      end
    end
    // committed copy survives reset, stands for non-volatile bits
    always_ff @(posedge clk) begin
      if (reset) begin
        // a blank committed copy reads as open
        case (perm_q[g])
          2'(fpepc_pkg::PROT_RO), 2'(fpepc_pkg::PROT_XO): begin
            perm_q[g] <= perm_q[g];                           // see (R16)
          end
          default: perm_q[g] <= 2'(fpepc_pkg::PROT_RW);
        endcase
      end else if (wr && paddr == fpepc_pkg::OFF_COMMIT
          && pwdata[1:0] == fpepc_pkg::COMMIT_KEY) begin
        perm_q[g] <= prot_q[g];                               // see (R16)
      end else if (perm_q[g] == 2'b11) begin
        perm_q[g] <= 2'(fpepc_pkg::PROT_RW);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= fpepc_pkg::ST_IDLE;
      busy    <= 1'b0;
      fail_q  <= 1'b0;
      tick_q  <= 8'h00;
      us_q    <= 8'h00;
      wcnt_q  <= 8'h00;
      idx_q   <= 12'h000;
    end else begin
      if (state_q != fpepc_pkg::ST_IDLE) begin
        tick_q <= us_tick ? 8'h00 : tick_q + 8'h01;           // see (R8)
      end
      unique case (state_q)
        fpepc_pkg::ST_IDLE: begin
          if (start_bad) fail_q <= 1'b1;                      // see (R5)
          if (start_ok) begin
            fail_q <= 1'b0;
            busy   <= 1'b1;
            tick_q <= 8'h00;
            us_q   <= 8'h00;
            wcnt_q <= 8'h00;
            if (pwdata[2:0] == fpepc_pkg::CMD_ERASE) begin
              state_q <= fpepc_pkg::ST_ERASE;
              idx_q   <= {addr_q[13:10], 8'h00};              // see (R1)
            end else begin
              state_q <= fpepc_pkg::ST_PROG;
              idx_q   <= addr_q[13:2];
            end
          end
        end
        fpepc_pkg::ST_PROG, fpepc_pkg::ST_ERASE: begin
          if (op_end) begin
            state_q <= fpepc_pkg::ST_IDLE;
            busy    <= 1'b0;
          end else if (us_tick) begin
            if (us_q + 8'h01 >= us_goal) begin
              us_q   <= 8'h00;
              wcnt_q <= wcnt_q + 8'h01;
            end else begin
              us_q <= us_q + 8'h01;
            end
          end
        end
        default: state_q <= fpepc_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array writes: erase sets one word to ones per pulse, program ANDs
  always_ff @(posedge clk) begin
    if (us_tick && us_q + 8'h01 >= us_goal) begin
      if (state_q == fpepc_pkg::ST_ERASE) begin
        mem_q[{idx_q[11:8], wcnt_q}] <= fpepc_pkg::ERASED;    // see (R1)
      end else if (state_q == fpepc_pkg::ST_PROG) begin
        mem_q[idx_q] <= mem_q[idx_q] & data_q;                // see (R6)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data reads over apb and the fetch port; blocked reads return zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q   <= 32'h00000000;
      fetch_rsp <= '0;
    end else begin
      if (wr && paddr == fpepc_pkg::OFF_CMD
          && pwdata[2:0] == fpepc_pkg::CMD_READ) begin
        rdata_q <= rd_bad ? 32'h00000000 : mem_q[addr_q[13:2]]; // see (R19)
      end
      fetch_rsp.valid <= fetch_req.valid;
      fetch_rsp.error <= fetch_bad;
      fetch_rsp.data  <= fetch_bad ? 32'h00000000
                         : mem_q[fetch_req.addr[13:2]];        // see (R19)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit 0 done, bit 1 violation; set wins over clear
  always_ff @(posedge clk) begin
    if (reset) begin
      ris_q <= 2'b00;
    end else begin
      ris_q <= (ris_q & ~((wr && paddr == fpepc_pkg::OFF_RIS)
                          ? pwdata[1:0] : 2'b00))             // see (R14)
               | {viol_ev, done_ev};                          // see (R10)
    end
  end

  // per source enables
  always_ff @(posedge clk) begin
    if (reset) begin
      im_q <= 2'b00;
    end else if (wr && paddr == fpepc_pkg::OFF_IM) begin
      im_q <= pwdata[1:0];                                    // see (R12)
    end
  end

  // level interrupt, one cycle behind the masked status
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ris_q & im_q);                                 // see (R12)
    end
  end
endmodule

// ### verilog/fpepc_pkg.sv
// package for the flash program, erase and protect controller
package fpepc_pkg;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned WORDS      = 4096;
  localparam int unsigned IDX_W      = 12;
  localparam int unsigned BLK_SHIFT  = 8;
  localparam int unsigned REGIONS    = 8;
  localparam int unsigned REG_SHIFT  = 9;
  localparam int unsigned BLK_WORDS  = 256;
  localparam logic [31:0] ERASED     = 32'hFFFFFFFF;
  localparam logic [7:0]  USEC_RESET = 8'h7D;
  localparam int unsigned PROG_US    = 20;
  localparam int unsigned ERASE_US   = 40;
  localparam logic [11:0] OFF_DATA   = 12'h000;
  localparam logic [11:0] OFF_ADDR   = 12'h004;
  localparam logic [11:0] OFF_CMD    = 12'h008;
  localparam logic [11:0] OFF_STAT   = 12'h00C;
  localparam logic [11:0] OFF_USEC   = 12'h010;
  localparam logic [11:0] OFF_RIS    = 12'h014;
  localparam logic [11:0] OFF_IM     = 12'h018;
  localparam logic [11:0] OFF_MIS    = 12'h01C;
  localparam logic [11:0] OFF_PROT   = 12'h020;
  localparam logic [11:0] OFF_COMMIT = 12'h024;
  localparam logic [11:0] OFF_RDATA  = 12'h028;
  localparam logic [2:0]  CMD_PROG   = 3'h1;
  localparam logic [2:0]  CMD_ERASE  = 3'h2;
  localparam logic [2:0]  CMD_READ   = 3'h4;
  localparam logic [1:0]  COMMIT_KEY = 2'h3;
  typedef enum logic [1:0] {
    PROT_RW = 2'b00,
    PROT_RO = 2'b01,
    PROT_XO = 2'b10
  } fpepc_prot_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PROG  = 2'b01,
    ST_ERASE = 2'b10
  } fpepc_state_t;
  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic [ADDR_W-1:0] addr;
  } fpepc_fetch_req_t;
  typedef struct packed {
    logic        valid;
    logic        error;
    logic [WORD_W-1:0] data;
  } fpepc_fetch_rsp_t;
endpackage

// ### verif/fpepc_top_props.sv
// port checker for the flash controller
`timescale 1ns/10ps
module fpepc_top_props (
  input logic                        clk,       // clock
  input logic                        reset,     // reset
  input logic                        psel,      // select
  input logic                        penable,   // enable
  input logic                        pwrite,    // direction
  input logic [11:0]                 paddr,     // address
  input logic [31:0]                 pwdata,    // write data
  input logic [31:0]                 prdata,    // read data
  input logic                        pready,    // ready
  input logic                        pslverr,   // error
  input fpepc_pkg::fpepc_fetch_req_t fetch_req, // read request
  input fpepc_pkg::fpepc_fetch_rsp_t fetch_rsp, // read answer
  input logic                        busy,      // running
  input logic                        irq        // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rsp_timing: assert property (fetch_req.valid |=> fetch_rsp.valid)
    else $error("read answer late");
  a_fetch_ok: assert property (fetch_req.valid && fetch_req.fetch
    |=> !fetch_rsp.error) else $error("fetch refused");
  a_block_zero: assert property (fetch_rsp.error |->
    fetch_rsp.valid && fetch_rsp.data == '0) else $error("data leaked");
  a_busy_cause: assert property ($rose(busy) |->
    $past(pwrite && pready) || $past(pwrite && pready, 2))
    else $error("busy without command");
  a_irq_clear: assert property (pready && pwrite && !busy &&
    paddr == fpepc_pkg::OFF_RIS && pwdata[1:0] == 2'h3 |=> ##1 !irq)
    else $error("irq not cleared");
  a_reset_quiet: assert property (disable iff (1'b0)
    reset |=> !busy && !irq && !pready && !fetch_rsp.valid)
    else $error("outputs active after reset");
  c_refused: cover property (fetch_rsp.error);
  c_done: cover property ($fell(busy));
  c_irq: cover property ($rose(irq));
endmodule
bind fpepc_top fpepc_top_props u_props (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fetch_req(fetch_req), .fetch_rsp(fetch_rsp), .busy(busy), .irq(irq));

// ### verif/fpepc_core_model.sv
// core and debugger model issuing flash reads
`timescale 1ns/10ps
module fpepc_core_model (
  input  logic                        clk,      // clock
  input  logic                        go,       // issue one read
  input  logic                        fetch,    // 1 fetch, 0 data
  input  logic [15:0]                 addr,     // byte address
  output fpepc_pkg::fpepc_fetch_req_t fetch_req // to flash
);
  // idle lines toggle so a stale value is never trusted
  always_ff @(posedge clk) begin
    fetch_req.valid <= go;
    fetch_req.fetch <= go ? fetch : ~fetch_req.fetch;
    fetch_req.addr  <= go ? {addr[15:2], 2'h0} : ~fetch_req.addr;
  end
endmodule

// ### verif/flash_program_erase_protect_ctrl_tb.sv
// testbench for the flash controller
`timescale 1ns/10ps
module flash_program_erase_protect_ctrl_tb;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr;
  logic        go, fetch, busy, irq, w, err;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, rd, d, e;
  logic [15:0] faddr;
  int          errors, compares, cyc, n1, n2;
  fpepc_pkg::fpepc_fetch_req_t fetch_req;
  fpepc_pkg::fpepc_fetch_rsp_t fetch_rsp;
  logic [76:0] rows [8];
  fpepc_top uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fetch_req(fetch_req),
    .fetch_rsp(fetch_rsp), .busy(busy), .irq(irq));
  fpepc_core_model core (.clk(clk), .go(go), .fetch(fetch), .addr(faddr),
    .fetch_req(fetch_req));
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [33:0] s, input logic [33:0] x);
    compares++;
    if (s !== x) begin
      errors++;
      $display("Error %s exp %h seen %h", n, x, s);
    end
  endtask
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [11:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk("reg", rd, x);
  endtask
  task run(input logic [2:0] cmd, output int n);
    apb(1'b1, fpepc_pkg::OFF_CMD, cmd);
    n = 0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0) begin
      n++;
      @(posedge clk);
    end
  endtask
  task fr(input logic f, input logic [15:0] ad, input logic [33:0] x);
    @(posedge clk);
    go <= 1'b1;
    fetch <= f;
    faddr <= ad;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    chk("read", fetch_rsp, x);
  endtask
  task final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    {reset, psel, penable, pwrite, go, fetch} = 6'h20;
    {paddr, pwdata, faddr, errors, compares, cyc} = '0;
    rows = '{{1'b0, 12'h010, 32'h0, 32'h7D}, {1'b1, 12'h010, 32'h1, 32'h0},
      {1'b0, 12'h010, 32'h0, 32'h1}, {1'b1, 12'h018, 32'h1, 32'h0},
      {1'b0, 12'h018, 32'h0, 32'h1}, {1'b0, 12'h014, 32'h0, 32'h0},
      {1'b0, 12'h00C, 32'h0, 32'h0}, {1'b0, 12'h020, 32'h0, 32'h0}};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("busy", {busy, irq}, 34'h0);
    foreach (rows[i]) begin
      {w, a, d, e} = rows[i];
      apb(w, a, d);
      if (!w) chk("row", rd, e);
    end
    run(fpepc_pkg::CMD_ERASE, n1);
    fr(1'b0, 16'h03FC, {2'h2, fpepc_pkg::ERASED});
    rdchk(fpepc_pkg::OFF_RIS, 32'h1);
    rdchk(fpepc_pkg::OFF_MIS, 32'h1);
    chk("irq", irq, 34'h1);
    apb(1'b1, fpepc_pkg::OFF_RIS, 32'h3);
    repeat (3) @(posedge clk);
    chk("irq", irq, 34'h0);
    apb(1'b1, fpepc_pkg::OFF_DATA, 32'h12345678);
    run(fpepc_pkg::CMD_PROG, n1);
    apb(1'b1, fpepc_pkg::OFF_DATA, 32'hFFFF00FF);
    apb(1'b1, fpepc_pkg::OFF_USEC, 32'h2);
    run(fpepc_pkg::CMD_PROG, n2);
    chk("pulse", 34'(n2 - n1), 34'(fpepc_pkg::PROG_US));
    fr(1'b0, 16'h0000, {2'h2, 32'h12340078});
    apb(1'b1, fpepc_pkg::OFF_CMD, 32'(fpepc_pkg::CMD_READ));
    rdchk(fpepc_pkg::OFF_RDATA, 32'h12340078);
    apb(1'b1, fpepc_pkg::OFF_RIS, 32'h1);
    apb(1'b1, fpepc_pkg::OFF_PROT, 32'h100);
    apb(1'b1, fpepc_pkg::OFF_DATA, 32'h0);
    run(fpepc_pkg::CMD_PROG, n1);
    rdchk(fpepc_pkg::OFF_STAT, 32'h2);
    rdchk(fpepc_pkg::OFF_RIS, 32'h2);
    chk("irq", irq, 34'h0);
    fr(1'b0, 16'h0000, {2'h2, 32'h12340078});
    apb(1'b1, fpepc_pkg::OFF_PROT, 32'h0);
    rdchk(fpepc_pkg::OFF_PROT, 32'h1);
    apb(1'b1, fpepc_pkg::OFF_ADDR, 32'h0800);
    rdchk(fpepc_pkg::OFF_PROT, 32'h0);
    apb(1'b1, fpepc_pkg::OFF_ADDR, 32'h0);
    apb(1'b1, fpepc_pkg::OFF_PROT, 32'h200);
    rdchk(fpepc_pkg::OFF_PROT, 32'h2);
    fr(1'b0, 16'h0000, {2'h3, 32'h0});
    fr(1'b1, 16'h0000, {2'h2, 32'h12340078});
    apb(1'b1, fpepc_pkg::OFF_CMD, 32'(fpepc_pkg::CMD_READ));
    rdchk(fpepc_pkg::OFF_RDATA, 32'h0);
    apb(1'b1, fpepc_pkg::OFF_RIS, 32'h3);
    run(fpepc_pkg::CMD_ERASE, n1);
    rdchk(fpepc_pkg::OFF_STAT, 32'h2);
    rdchk(fpepc_pkg::OFF_RIS, 32'h2);
    fr(1'b1, 16'h0000, {2'h2, 32'h12340078});
    apb(1'b0, 12'h02C, 32'h0);
    chk("slverr", err, 34'h1);
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rdchk(fpepc_pkg::OFF_PROT, 32'h0);
    apb(1'b1, fpepc_pkg::OFF_PROT, 32'h100);
    apb(1'b1, fpepc_pkg::OFF_COMMIT, 32'h3);
    apb(1'b1, fpepc_pkg::OFF_PROT, 32'h200);
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rdchk(fpepc_pkg::OFF_PROT, 32'h1);
    final_report;
  end
endmodule
